// ===== rtl/tcg_clock_gen.sv
// triple clock generator: oscillator control, slow clock, pll handshake and system divider
`timescale 1ns/1ps

// What this block does
// - main clock comes from the crystal oscillator or an external clock on its input.
// - stop-main request halts the main oscillator and presets its 14-bit timer.
// - after release the timer counts down, halts at zero, raises main-clock-good.
// - main start-up delay equals 32,766 main clock cycles (preset 16,383 decrements of two edges each).
// - stop-slow request disables slow oscillator and presets its 6-bit timer.
// - after release the 6-bit timer counts down and raises slow-clock-good at zero.
// - slow prescaler is divide-by-two plus 8-bit divider, ratios 2 to 512.
// - software picks slow source; prescaled main clock after reset.
// - slow oscillator source disables prescaler, only once that oscillator toggles.
// - pll multiplies main clock by three, four or five.
// - fast select reads zero only once the pll is stable.
// - writing one to fast select returns system clock to main clock.
// - system clock passes a divider with ratios one to sixteen.
// - fast select zero means pll, one means main clock; reset value one.
// - slow select zero means prescaled main clock, one slow oscillator.
// - switching to the pll is ignored while pll power-down is set.
// - internal reset releases after main timer reaches zero and reset pin is high.
module tcg_clock_gen
  import tcg_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // oscillator pins and power management
  input  wire logic                main_osc_in,
  input  wire logic                slow_osc_in,
  input  wire logic                ext_clk_mode,
  input  wire logic                stop_main_osc,
  input  wire logic                stop_slow_osc,
  input  wire logic                ext_reset_n,
  // pll analog side
  input  wire logic                pll_clk_in,
  input  wire logic                pll_locked,
  // software control
  input  wire logic                slow_clock_select,
  input  wire logic                pll_power_down,
  input  wire logic [1:0]          pll_mult,
  input  wire logic [PRE_W-1:0]    slow_prescale,
  input  wire logic [SYSDIV_W-1:0] sys_div,
  input  wire logic                fcs_wr,
  input  wire logic                fcs_wdata,
  // oscillator and pll controls
  output logic                     main_osc_en,
  output logic                     main_osc_out,
  output logic                     slow_osc_en,
  output logic                     pll_en,
  output logic [2:0]               pll_factor,
  // status and clocks
  output logic                     main_clk_good,
  output logic                     slow_clk_good,
  output logic                     fast_clock_select,
  output logic                     slow_clk,
  output logic                     sys_clk_tick,
  output logic                     internal_rst_n
);

  tcg_state_t st;
  tcg_state_t next_st;

  tcg_timer_if #(.W(MAIN_TMR_W)) main_if ();
  tcg_timer_if #(.W(SLOW_TMR_W)) slow_if ();

  logic main_edge;
  logic slow_edge;
  logic pll_edge;

  // ****************************************************************
  // start-up timers
  // ****************************************************************
  // oscillator inputs arrive synchronous, so a one-flop edge detect suffices
  assign main_edge    = main_osc_in & ~st.main_prev;
  assign slow_edge    = slow_osc_in & ~st.slow_prev;
  assign pll_edge     = pll_clk_in & ~st.pll_prev;
  assign main_if.stop = stop_main_osc;
  assign main_if.tick = main_edge;
  assign slow_if.stop = stop_slow_osc;
  assign slow_if.tick = slow_edge;

  tcg_startup_timer #(.W(MAIN_TMR_W), .STEP(MAIN_TMR_STEP), .PRESET(MAIN_PRESET)) u_main_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tif     (main_if.tmr)
  );

  tcg_startup_timer #(.W(SLOW_TMR_W), .STEP(SLOW_TMR_STEP), .PRESET(SLOW_PRESET)) u_slow_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tif     (slow_if.tmr)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    logic cur_lvl;
    logic new_lvl;
    logic want_src;
    cur_lvl  = 1'b0;
    new_lvl  = 1'b0;
    want_src = SLOW_SRC_PRESCALED;
    next_st  = st;
    next_st.main_prev = main_osc_in;
    next_st.slow_prev = slow_osc_in;
    next_st.pll_prev  = pll_clk_in;

    // oscillator enables; crystal amplifier idles in external clock mode
    next_st.main_osc_en = ~stop_main_osc;
    next_st.xtal_drive  = ~stop_main_osc & ~ext_clk_mode;
    next_st.slow_osc_en = ~stop_slow_osc;

    // slow prescaler, held cleared while the slow oscillator is in use
    if (st.slow_src == SLOW_SRC_OSC) begin
      next_st.pre_cnt = '0;
      next_st.pre_clk = 1'b0;
    end else if (main_edge) begin
      if (tcg_div_wrap(st.pre_cnt, slow_prescale)) begin
        next_st.pre_cnt = '0;
        next_st.pre_clk = ~st.pre_clk;
      end else begin
        next_st.pre_cnt = st.pre_cnt + 1'b1;
      end
    end

    // slow source: osc only when it is proven toggling
    want_src = (slow_clock_select == SLOW_SRC_OSC && slow_if.good) ? SLOW_SRC_OSC
                                                                   : SLOW_SRC_PRESCALED;
    cur_lvl  = (st.slow_src == SLOW_SRC_OSC) ? slow_osc_in : next_st.pre_clk;
    new_lvl  = (want_src == SLOW_SRC_OSC) ? slow_osc_in : next_st.pre_clk;
    if (want_src != st.slow_src) begin
      // a dead oscillator may be frozen high, so leave it at once
      if (!slow_if.good || (!cur_lvl && !new_lvl)) begin
        next_st.slow_src = want_src;
      end
    end
    next_st.slow_clk = (next_st.slow_src == SLOW_SRC_OSC) ? slow_osc_in : next_st.pre_clk;

    // fast select: set always works, clear needs a powered, locked pll
    if (pll_power_down) begin
      next_st.fast_sel = FCS_MAIN;
    end else if (fcs_wr && fcs_wdata == FCS_MAIN) begin
      next_st.fast_sel = FCS_MAIN;
    end else if (fcs_wr && pll_locked) begin
      next_st.fast_sel = FCS_PLL;
    end

    // pll control
    next_st.pll_en = ~pll_power_down;
    unique case (pll_mult)
      MULT_X3: next_st.pll_factor = FACT_X3;
      MULT_X4: next_st.pll_factor = FACT_X4;
      MULT_X5: next_st.pll_factor = FACT_X5;
      default: next_st.pll_factor = st.pll_factor; // reserved code keeps factor
    endcase

    // system divider; source swaps at a wrap, save on pll power-down, so no phase is cut
    next_st.sys_tick = 1'b0;
    if ((st.sys_src == FCS_MAIN) ? main_edge : pll_edge) begin
      if (tcg_div_wrap({4'h0, st.sys_cnt}, {4'h0, sys_div})) begin
        next_st.sys_cnt  = '0;
        next_st.sys_tick = 1'b1;
        next_st.sys_src  = st.fast_sel;
      end else begin
        next_st.sys_cnt = st.sys_cnt + 1'b1;
      end
    end
    // pll gone away: fall back at once, its edges may never come
    if (st.sys_src == FCS_PLL && pll_power_down) begin
      next_st.sys_src = FCS_MAIN;
      next_st.sys_cnt = '0;
    end

    // power-on reset release
    if (main_if.good) begin
      next_st.por_done = 1'b1;
    end
    next_st.int_rst_n = next_st.por_done & ext_reset_n;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign main_osc_en       = st.main_osc_en;
  assign main_osc_out      = st.xtal_drive;
  assign slow_osc_en       = st.slow_osc_en;
  assign pll_en            = st.pll_en;
  assign pll_factor        = st.pll_factor;
  assign main_clk_good     = main_if.good;
  assign slow_clk_good     = slow_if.good;
  assign fast_clock_select = st.fast_sel;
  assign slow_clk          = st.slow_clk;
  assign sys_clk_tick      = st.sys_tick;
  assign internal_rst_n    = st.int_rst_n;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_main_good_stop : assert property (stop_main_osc |=> !main_clk_good)
    else $error("main good high during stop");
  a_slow_good_stop : assert property (stop_slow_osc |=> !slow_clk_good)
    else $error("slow good high during stop");
  a_main_good_zero : assert property (main_clk_good |-> main_if.count == '0)
    else $error("main good with timer not at zero");
  a_xtal_mode : assert property (ext_clk_mode |=> !main_osc_out)
    else $error("crystal driven in external clock mode");
  a_pll_pwd_block : assert property (pll_power_down |=> fast_clock_select == FCS_MAIN)
    else $error("pll selected while powered down");
  a_pll_unlocked : assert property (fcs_wr && !pll_locked && fast_clock_select == FCS_MAIN
                                    |=> fast_clock_select == FCS_MAIN)
    else $error("fast select cleared before lock");
  a_fcs_set_main : assert property (fcs_wr && fcs_wdata == FCS_MAIN |=> fast_clock_select == FCS_MAIN)
    else $error("fast select set ignored");
  a_slow_needs_osc : assert property (!slow_clk_good |=> st.slow_src == SLOW_SRC_PRESCALED)
    else $error("slow osc used without toggling");
  a_pre_disabled : assert property (st.slow_src == SLOW_SRC_OSC ##1 st.slow_src == SLOW_SRC_OSC
                                    |-> st.pre_cnt == '0 && !st.pre_clk)
    else $error("prescaler runs on slow osc");
  a_pll_factor : assert property (pll_mult == MULT_X5 |=> pll_factor == FACT_X5)
    else $error("pll factor wrong");
  a_int_rst_pin : assert property (!ext_reset_n |=> !internal_rst_n)
    else $error("internal reset released with pin low");
  a_int_rst_por : assert property (!st.por_done |-> !internal_rst_n)
    else $error("internal reset released before timer");

  c_main_good : cover property ($rose(main_clk_good));
  c_slow_osc  : cover property ($rose(st.slow_src));
  c_pll_on    : cover property ($fell(fast_clock_select));
  c_rst_out   : cover property ($rose(internal_rst_n));

endmodule : tcg_clock_gen

// ===== rtl/tcg_pkg.sv
// constants, types and helpers shared by the triple clock generator
package tcg_pkg;

  // ****************************************************************
  // start-up timers
  // ****************************************************************
  localparam int              MAIN_TMR_W          = 14;
  localparam logic [13:0]     MAIN_PRESET         = 14'h3fff;
  localparam int              MAIN_STARTUP_CYCLES = 32768;
  // main clock edges per timer decrement, derived from the delay
  localparam int              MAIN_TMR_STEP       = MAIN_STARTUP_CYCLES / (2 ** MAIN_TMR_W);
  localparam int              SLOW_TMR_W          = 6;
  localparam logic [5:0]      SLOW_PRESET         = 6'h3f;
  localparam int              SLOW_TMR_STEP       = 1;

  // ****************************************************************
  // dividers and selects
  // ****************************************************************
  localparam int              PRE_W              = 8;
  localparam int              SYSDIV_W           = 4;
  localparam logic            FCS_PLL            = 1'b0;
  localparam logic            FCS_MAIN           = 1'b1;
  localparam logic            SLOW_SRC_PRESCALED = 1'b0;
  localparam logic            SLOW_SRC_OSC       = 1'b1;

  // ****************************************************************
  // pll multiplication codes and factors
  // ****************************************************************
  localparam logic [1:0]      MULT_X3 = 2'h0;
  localparam logic [1:0]      MULT_X4 = 2'h1;
  localparam logic [1:0]      MULT_X5 = 2'h2;
  localparam logic [2:0]      FACT_X3 = 3'h3;
  localparam logic [2:0]      FACT_X4 = 3'h4;
  localparam logic [2:0]      FACT_X5 = 3'h5;

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  typedef struct packed {
    logic                main_prev;
    logic                slow_prev;
    logic                pll_prev;
    logic [PRE_W-1:0]    pre_cnt;
    logic                pre_clk;
    logic                slow_src;
    logic                slow_clk;
    logic                fast_sel;
    logic                sys_src;
    logic [SYSDIV_W-1:0] sys_cnt;
    logic                sys_tick;
    logic                por_done;
    logic                int_rst_n;
    logic                main_osc_en;
    logic                xtal_drive;
    logic                slow_osc_en;
    logic                pll_en;
    logic [2:0]          pll_factor;
  } tcg_state_t;

  localparam tcg_state_t ST_RESET = '{
    main_prev: 1'b0, slow_prev: 1'b0, pll_prev: 1'b0,
    pre_cnt: 8'h00, pre_clk: 1'b0, slow_src: SLOW_SRC_PRESCALED, slow_clk: 1'b0,
    fast_sel: FCS_MAIN, sys_src: FCS_MAIN, sys_cnt: 4'h0, sys_tick: 1'b0,
    por_done: 1'b0, int_rst_n: 1'b0, main_osc_en: 1'b0, xtal_drive: 1'b0,
    slow_osc_en: 1'b0, pll_en: 1'b0, pll_factor: FACT_X3};

  // a divider counter has reached its limit
  function automatic logic tcg_div_wrap(input logic [7:0] cnt, input logic [7:0] lim);
    return cnt >= lim;
  endfunction : tcg_div_wrap

endpackage : tcg_pkg

// ===== rtl/tcg_timer_if.sv
// link between the sequencer and one oscillator start-up timer
`timescale 1ns/1ps
interface tcg_timer_if #(parameter int W = 6);
  logic         stop;
  logic         tick;
  logic         good;
  logic [W-1:0] count;
  modport ctl (output stop, output tick, input good, input count);
  modport tmr (input stop, input tick, output good, output count);
endinterface : tcg_timer_if

// ===== rtl/tcg_startup_timer.sv
// oscillator start-up down counter with clock-good flag
`timescale 1ns/1ps
module tcg_startup_timer
  import tcg_pkg::*;
#(
  parameter int          W      = 6,
  parameter int          STEP   = 1,
  parameter logic [W-1:0] PRESET = '1
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // sequencer side
  tcg_timer_if.tmr  tif
);

  typedef struct packed {
    logic         phase;
    logic [W-1:0] count;
    logic         good;
  } tcg_tmr_state_t;

  localparam logic PHASE_LAST = 1'(STEP - 1);

  tcg_tmr_state_t st;
  tcg_tmr_state_t next_st;

  // ****************************************************************
  // countdown
  // ****************************************************************
  // preset while stopped, count oscillator edges otherwise
  always_comb begin
    next_st = st;
    if (tif.stop) begin
      next_st.count = PRESET;
      next_st.phase = 1'b0;
      next_st.good  = 1'b0;
    end else if (st.count == '0) begin
      next_st.good = 1'b1; // halted at zero
    end else if (tif.tick) begin
      if (st.phase == PHASE_LAST) begin
        next_st.phase = 1'b0;
        next_st.count = st.count - 1'b1;
      end else begin
        next_st.phase = ~st.phase;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{phase: 1'b0, count: PRESET, good: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign tif.good  = st.good;
  assign tif.count = st.count;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_timer_preset : assert property (tif.stop |=> st.count == PRESET && !st.good)
    else $error("timer not preset while stopped");
  a_timer_good : assert property (!tif.stop && st.count == '0 |=> st.good)
    else $error("timer at zero without good");
  a_timer_hold : assert property (st.good && !tif.stop |=> st.count == '0 && st.good)
    else $error("good dropped without stop");

endmodule : tcg_startup_timer

// ===== test/tcg_osc_model.sv
// oscillator, pll and lock stand-in on the far side of the clock generator
`timescale 1ns/1ps
module tcg_osc_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // enables from the generator
  input  wire logic main_osc_en,
  input  wire logic slow_osc_en,
  input  wire logic pll_en,
  // oscillator and pll samples
  output logic      main_osc_in,
  output logic      slow_osc_in,
  output logic      pll_clk_in,
  output logic      pll_locked
);
  logic [1:0] slow_div;
  logic [3:0] lock_cnt;

  // ****************************************************************
  // oscillators
  // ****************************************************************
  // a stopped source rests low so no false edge appears
  // pll runs slower than main so the two sources can be told apart
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_osc_in <= 1'b0;
      slow_osc_in <= 1'b0;
      pll_clk_in  <= 1'b0;
      slow_div    <= 2'h0;
      lock_cnt    <= 4'h0;
      pll_locked  <= 1'b0;
    end else begin
      main_osc_in <= main_osc_en & ~main_osc_in;
      slow_div    <= (slow_osc_en && slow_div != 2'h2) ? slow_div + 2'h1 : 2'h0;
      if (!slow_osc_en) slow_osc_in <= 1'b0;
      else if (slow_div == 2'h2) slow_osc_in <= ~slow_osc_in;
      if (!pll_en) pll_clk_in <= 1'b0;
      else if (main_osc_in) pll_clk_in <= ~pll_clk_in;
      lock_cnt    <= !pll_en ? 4'h0 : (lock_cnt == 4'hf) ? lock_cnt : lock_cnt + 4'h1;
      pll_locked  <= pll_en & (lock_cnt == 4'hf);
    end
  end
endmodule : tcg_osc_model

// ===== test/tb_top.sv
// self-checking bench for the triple clock generator
`timescale 1ns/1ps
module tb_top;
  import tcg_pkg::*;
  logic clk_sys, rst_n, main_osc_in, slow_osc_in, ext_clk_mode, stop_main_osc, stop_slow_osc;
  logic ext_reset_n, pll_clk_in, pll_locked, slow_clock_select, pll_power_down, fcs_wr, fcs_wdata;
  logic [1:0] pll_mult;
  logic [PRE_W-1:0] slow_prescale;
  logic [SYSDIV_W-1:0] sys_div;
  logic main_osc_en, main_osc_out, slow_osc_en, pll_en, main_clk_good, slow_clk_good;
  logic fast_clock_select, slow_clk, sys_clk_tick, internal_rst_n;
  logic [2:0] pll_factor;
  int miscompares, total_checks, i;
  // divider values that keep a 12 MHz main clock at or below 100 kHz once prescaled
  logic [7:0] pre_tab [3] = '{8'h3b, 8'h80, 8'hff};

  // ****************************************************************
  // clock, design and far side
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  tcg_clock_gen u_dut (.clk_sys, .rst_n, .main_osc_in, .slow_osc_in, .ext_clk_mode, .stop_main_osc,
    .stop_slow_osc, .ext_reset_n, .pll_clk_in, .pll_locked, .slow_clock_select, .pll_power_down,
    .pll_mult, .slow_prescale, .sys_div, .fcs_wr, .fcs_wdata, .main_osc_en, .main_osc_out,
    .slow_osc_en, .pll_en, .pll_factor, .main_clk_good, .slow_clk_good, .fast_clock_select,
    .slow_clk, .sys_clk_tick, .internal_rst_n);
  tcg_osc_model u_osc (.clk_sys, .rst_n, .main_osc_en, .slow_osc_en, .pll_en, .main_osc_in,
    .slow_osc_in, .pll_clk_in, .pll_locked);

  // ****************************************************************
  // tasks
  // ****************************************************************
  // sample just after the edge so its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic timeout(input string what);
    miscompares++;
    $display("Error %s expected event seen none", what);
    final_report();
  endtask : timeout
  // bounded wait for a clock-good flag, sel 1 slow, 0 main
  task automatic wait_good(input string what, input logic sel, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      if ((sel ? slow_clk_good : main_clk_good) === 1'b1) break;
      cyc(1);
    end
    if (n == lim) timeout(what);
  endtask : wait_good
  // cycles between rising edges, sel 1 system tick, 0 slow clock; first gap skipped
  task automatic gap(input string what, input logic sel, input int exp);
    int n, k, t0;
    logic p, v;
    p = 1'b1;
    k = 0;
    t0 = 0;
    for (n = 0; n < 5000 && k < 3; n++) begin
      cyc(1);
      v = sel ? sys_clk_tick : slow_clk;
      if (v === 1'b1 && p === 1'b0) begin
        if (k == 2) check(what, n - t0, exp);
        t0 = n;
        k++;
      end
      p = v;
    end
    if (k < 3) timeout(what);
    $display("test %s done", what);
  endtask : gap
  // fast select write: strobe held through one taking edge
  task automatic fcs_write(input logic d);
    @(posedge clk_sys);
    fcs_wr <= 1'b1;
    fcs_wdata <= d;
    @(posedge clk_sys);
    fcs_wr <= 1'b0;
    cyc(1);
  endtask : fcs_write

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0; stop_main_osc = 1'b1; stop_slow_osc = 1'b1; ext_clk_mode = 1'b0; ext_reset_n = 1'b0;
    slow_clock_select = 1'b0; pll_power_down = 1'b1; pll_mult = 2'h0; slow_prescale = 8'h00;
    sys_div = 4'h0; fcs_wr = 1'b0; fcs_wdata = 1'b0; miscompares = 0; total_checks = 0;
    cyc(2);
    check("fcs reset", fast_clock_select, 1'b1);
    check("factor reset", pll_factor, FACT_X3);
    check("good reset", main_clk_good, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(2);
    check("main timer preset", main_clk_good, 1'b0);
    @(posedge clk_sys);
    stop_main_osc <= 1'b0;
    cyc(2);
    check("crystal drive", main_osc_out, 1'b1);
    // main edges arrive every 2 cycles, 2 edges per decrement
    cyc(65500);
    check("main good early", main_clk_good, 1'b0);
    wait_good("main good", 1'b0, 100);
    cyc(3);
    check("reset pin held", internal_rst_n, 1'b0);
    @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    cyc(3);
    check("reset released", internal_rst_n, 1'b1);
    $display("test main start done");
    // slow osc rises every 6 cycles, one decrement each
    @(posedge clk_sys);
    stop_slow_osc <= 1'b0;
    cyc(300);
    check("slow good early", slow_clk_good, 1'b0);
    wait_good("slow good", 1'b1, 150);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      slow_prescale <= pre_tab[i];
      gap("prescaled slow", 1'b0, 4 * (pre_tab[i] + 1));
    end
    // osc selected while it is not toggling: prescaler stays
    @(posedge clk_sys);
    stop_slow_osc <= 1'b1;
    slow_prescale <= 8'h3b;
    slow_clock_select <= 1'b1;
    cyc(2);
    check("slow good drop", slow_clk_good, 1'b0);
    check("slow osc stopped", slow_osc_en, 1'b0);
    gap("slow no toggle", 1'b0, 240);
    @(posedge clk_sys);
    stop_slow_osc <= 1'b0;
    wait_good("slow good again", 1'b1, 500);
    gap("slow osc src", 1'b0, 6);
    @(posedge clk_sys);
    stop_slow_osc <= 1'b1;
    gap("slow fallback", 1'b0, 240);
    @(posedge clk_sys);
    slow_clock_select <= 1'b0;
    for (i = 0; i < 16; i += 15) begin
      @(posedge clk_sys);
      sys_div <= 4'(i);
      gap("sys div main", 1'b1, 2 * (i + 1));
    end
    // factor set before the pll is used
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      pll_mult <= 2'(i);
      cyc(2);
      check("pll factor", pll_factor, (i == 3) ? 3'h5 : 3'(i + 3));
    end
    fcs_write(1'b0);
    check("fcs while off", fast_clock_select, 1'b1);
    @(posedge clk_sys);
    pll_power_down <= 1'b0;
    sys_div <= 4'h1;
    fcs_write(1'b0);
    check("fcs before lock", fast_clock_select, 1'b1);
    check("pll enabled", pll_en, 1'b1);
    for (i = 0; i < 20 && fast_clock_select !== 1'b0; i++) fcs_write(1'b0);
    check("fcs on pll", fast_clock_select, FCS_PLL);
    gap("sys div pll", 1'b1, 8);
    fcs_write(1'b1);
    check("fcs back", fast_clock_select, FCS_MAIN);
    gap("sys div back", 1'b1, 4);
    @(posedge clk_sys);
    ext_clk_mode <= 1'b1;
    stop_main_osc <= 1'b1;
    cyc(2);
    check("ext clock drive", main_osc_out, 1'b0);
    check("main stopped", main_osc_en, 1'b0);
    check("main good drop", main_clk_good, 1'b0);
    $display("test stop main done");
    final_report();
  end
endmodule : tb_top
